// File: design/tap_pkg.sv
// Constants and types for the boundary-scan test access port
// Function
// (R01) Five clocks with mode select high reset
// (R02) Tester must reset controller after power-up
// (R03) Tester resets controller before FIFO traffic
// (R04) State changes on test clock rising edge
// (R05) Test logic takes priority over FIFO
// (R06) Test-logic-reset keeps all test logic disabled
// (R07) Run-test-idle acts only when instruction asks
// (R08) Select-DR branches to data path or IR
// (R09) Select-IR branches to instruction path or reset
// (R10) Capture-IR loads pattern ending in 01
// (R11) Shift-IR shifts instruction one bit per edge
// (R12) Exit1-IR to pause or update; pause holds
// (R13) Update-IR latches instruction on falling edge
// (R14) Capture-DR loads selected data register
// (R15) Data path states mirror instruction path
// (R16) Instruction register four bits, LSB nearest output
// (R17) Data registers parallel on shared serial path
// (R18) Bypass is one stage cleared in capture
// (R19) Bypass shifting leaves device operation unaffected
// (R20) Four inputs and one serial output
// (R21) Decode 02 ident, 01 scan, 03 hiz, 0F bypass
// (R22) Ident register 32 bits, bit zero one
// (R23) High-impedance disables outputs, selects bypass
// (R24) External-test instruction not supported
// (R25) Undecoded codes select bypass
package tap_pkg;
    localparam int IR_W = 4;
    localparam int ID_W = 32;
    localparam logic [IR_W-1:0] IR_CAPTURE = 4'h1;
    localparam logic [IR_W-1:0] OP_SCAN = 4'h1;
    localparam logic [IR_W-1:0] OP_IDENT = 4'h2;
    localparam logic [IR_W-1:0] OP_HIZ = 4'h3;
    localparam logic [IR_W-1:0] OP_BYPASS = 4'hF;
    // Reset value makes the identity register current after reset
    localparam logic [IR_W-1:0] IR_RESET = OP_IDENT;
    // Identity value is arbitrary; bit zero must stay one
    localparam logic [ID_W-1:0] ID_VALUE = 32'h1234_5679;
    localparam int TMS_RESET_CLOCKS = 5;

    typedef enum logic [3:0] {
        ST_RESET = 4'h0,
        ST_IDLE = 4'h1,
        ST_SEL_DR = 4'h2,
        ST_CAP_DR = 4'h3,
        ST_SHIFT_DR = 4'h4,
        ST_EXIT1_DR = 4'h5,
        ST_PAUSE_DR = 4'h6,
        ST_EXIT2_DR = 4'h7,
        ST_UPD_DR = 4'h8,
        ST_SEL_IR = 4'h9,
        ST_CAP_IR = 4'hA,
        ST_SHIFT_IR = 4'hB,
        ST_EXIT1_IR = 4'hC,
        ST_PAUSE_IR = 4'hD,
        ST_EXIT2_IR = 4'hE,
        ST_UPD_IR = 4'hF
    } tap_state_t;

    typedef enum logic [1:0] {
        SEL_BYPASS = 2'h0,
        SEL_SCAN = 2'h1,
        SEL_IDENT = 2'h2
    } dr_sel_t;
endpackage

// File: design/tap_sync.sv
// Two-stage synchroniser for test port pins
`timescale 1ns/1ps
`default_nettype none
module tap_sync #(
    parameter int W = 1
) (
    input wire logic clock,
    input wire logic resetn,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_r;

    if (W < 1) begin : g_w_check
        $error("tap_sync: W must be at least 1");
    end

    // Test pins idle high, so resetting high keeps a false edge from following reset
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            meta_r <= '1;
            q <= '1;
        end else begin
            meta_r <= d;
            q <= meta_r;
        end
    end
endmodule
`default_nettype wire

// File: design/tap_shift_reg.sv
// Capture and shift stage used for scan-path registers
`timescale 1ns/1ps
`default_nettype none
module tap_shift_reg #(
    parameter int W = 8
) (
    input wire logic clock,
    input wire logic resetn,
    input wire logic capture,
    input wire logic shift,
    input wire logic [W-1:0] cap_value,
    input wire logic serial_in,
    output logic [W-1:0] value
);
    if (W < 2) begin : g_w_check
        $error("tap_shift_reg: W must be at least 2");
    end

    // Shift toward bit zero, which feeds the serial output
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            value <= '0;
        end else if (capture) begin
            value <= cap_value;
        end else if (shift) begin
            value <= {serial_in, value[W-1:1]};
        end
    end
endmodule
`default_nettype wire

// File: design/tap_ctrl.sv
// Boundary-scan test access port controller with instruction and data registers
`timescale 1ns/1ps
`default_nettype none
module tap_ctrl #(
    parameter int SCAN_W = 16
) (
    input wire logic clock,
    input wire logic resetn,
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    input wire logic trst_n,
    output logic tdo,
    output logic tdo_oe,
    input wire logic [SCAN_W-1:0] scan_pins_in,
    output logic [SCAN_W-1:0] scan_preload,
    output logic outputs_disable,
    output logic test_active,
    output logic test_reset
);
    if (SCAN_W < 2) begin : g_scan_w_check
        $error("tap_ctrl: SCAN_W must be at least 2");
    end

    localparam int SYNC_W = 4;
    logic [SYNC_W-1:0] pins_s;
    logic tck_s, tms_s, tdi_s, trstn_s;
    logic tck_d_r;
    logic rise, fall;
    tap_pkg::tap_state_t state_r, state_nxt;
    logic [tap_pkg::IR_W-1:0] ir_shift_r;
    logic [tap_pkg::IR_W-1:0] ir_r;
    logic bypass_r;
    logic [tap_pkg::ID_W-1:0] id_value;
    logic [SCAN_W-1:0] scan_value;
    logic hiz_r;
    tap_pkg::dr_sel_t sel;
    logic cap_dr, shift_dr, upd_dr_fall;
    logic [2:0] tms_high_cnt_r;

    tap_sync #(.W(SYNC_W)) u_sync (
        .clock(clock),
        .resetn(resetn),
        .d({tck, tms, tdi, trst_n}),
        .q(pins_s)
    );
    assign tck_s = pins_s[3];
    assign tms_s = pins_s[2];
    assign tdi_s = pins_s[1];
    assign trstn_s = pins_s[0];

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            // Test clock rests high; resetting low would fake a rise
            tck_d_r <= 1'b1;
        end else begin
            tck_d_r <= tck_s;
        end
    end
    assign rise = tck_s & ~tck_d_r;
    assign fall = ~tck_s & tck_d_r;

    // Decoding used by capture, shift and output selection
    function automatic tap_pkg::dr_sel_t decode(input logic [tap_pkg::IR_W-1:0] op);
        unique case (op)
            tap_pkg::OP_IDENT: decode = tap_pkg::SEL_IDENT; // R21 R22
            tap_pkg::OP_SCAN: decode = tap_pkg::SEL_SCAN; // R21
            tap_pkg::OP_HIZ: decode = tap_pkg::SEL_BYPASS; // R23
            default: decode = tap_pkg::SEL_BYPASS; // R24 R25
        endcase
    endfunction
    assign sel = decode(ir_r); // R17

    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            tap_pkg::ST_RESET: state_nxt = tms_s ? tap_pkg::ST_RESET : tap_pkg::ST_IDLE;
            tap_pkg::ST_IDLE: state_nxt = tms_s ? tap_pkg::ST_SEL_DR : tap_pkg::ST_IDLE;
            tap_pkg::ST_SEL_DR: state_nxt = tms_s ? tap_pkg::ST_SEL_IR : tap_pkg::ST_CAP_DR; // R08
            tap_pkg::ST_CAP_DR: state_nxt = tms_s ? tap_pkg::ST_EXIT1_DR : tap_pkg::ST_SHIFT_DR;
            tap_pkg::ST_SHIFT_DR: state_nxt = tms_s ? tap_pkg::ST_EXIT1_DR : tap_pkg::ST_SHIFT_DR; // R15
            tap_pkg::ST_EXIT1_DR: state_nxt = tms_s ? tap_pkg::ST_UPD_DR : tap_pkg::ST_PAUSE_DR; // R15
            tap_pkg::ST_PAUSE_DR: state_nxt = tms_s ? tap_pkg::ST_EXIT2_DR : tap_pkg::ST_PAUSE_DR;
            tap_pkg::ST_EXIT2_DR: state_nxt = tms_s ? tap_pkg::ST_UPD_DR : tap_pkg::ST_SHIFT_DR;
            tap_pkg::ST_UPD_DR: state_nxt = tms_s ? tap_pkg::ST_SEL_DR : tap_pkg::ST_IDLE;
            tap_pkg::ST_SEL_IR: state_nxt = tms_s ? tap_pkg::ST_RESET : tap_pkg::ST_CAP_IR; // R09
            tap_pkg::ST_CAP_IR: state_nxt = tms_s ? tap_pkg::ST_EXIT1_IR : tap_pkg::ST_SHIFT_IR;
            tap_pkg::ST_SHIFT_IR: state_nxt = tms_s ? tap_pkg::ST_EXIT1_IR : tap_pkg::ST_SHIFT_IR;
            tap_pkg::ST_EXIT1_IR: state_nxt = tms_s ? tap_pkg::ST_UPD_IR : tap_pkg::ST_PAUSE_IR; // R12
            tap_pkg::ST_PAUSE_IR: state_nxt = tms_s ? tap_pkg::ST_EXIT2_IR : tap_pkg::ST_PAUSE_IR;
            tap_pkg::ST_EXIT2_IR: state_nxt = tms_s ? tap_pkg::ST_UPD_IR : tap_pkg::ST_SHIFT_IR;
            tap_pkg::ST_UPD_IR: state_nxt = tms_s ? tap_pkg::ST_SEL_DR : tap_pkg::ST_IDLE;
        endcase
    end

    // Device reset only clears the controller for simulation; the pin and mode select are the real resets
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            state_r <= tap_pkg::ST_RESET;
        end else if (!trstn_s) begin
            state_r <= tap_pkg::ST_RESET;
        end else if (rise) begin
            state_r <= state_nxt; // R04 R01
        end
    end

    // Counts test clocks with mode select high, to check the five-clock reset
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            tms_high_cnt_r <= '0;
        end else if (rise) begin
            if (!tms_s) begin
                tms_high_cnt_r <= '0;
            end else if (tms_high_cnt_r != 3'(tap_pkg::TMS_RESET_CLOCKS)) begin
                tms_high_cnt_r <= tms_high_cnt_r + 3'h1;
            end
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            ir_shift_r <= '0;
        end else if (rise && state_r == tap_pkg::ST_CAP_IR) begin
            ir_shift_r <= tap_pkg::IR_CAPTURE; // R10
        end else if (rise && state_r == tap_pkg::ST_SHIFT_IR) begin
            ir_shift_r <= {tdi_s, ir_shift_r[tap_pkg::IR_W-1:1]}; // R11 R16
        end
    end

    // Pause and exit states leave the shift stages untouched
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            ir_r <= tap_pkg::IR_RESET;
        end else if (state_r == tap_pkg::ST_RESET) begin
            ir_r <= tap_pkg::IR_RESET; // R06
        end else if (fall && state_r == tap_pkg::ST_UPD_IR) begin
            ir_r <= ir_shift_r; // R13 R12
        end
    end

    assign cap_dr = rise && state_r == tap_pkg::ST_CAP_DR; // R14
    assign shift_dr = rise && state_r == tap_pkg::ST_SHIFT_DR; // R15
    assign upd_dr_fall = fall && state_r == tap_pkg::ST_UPD_DR;

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            bypass_r <= 1'b0;
        end else if (cap_dr && sel == tap_pkg::SEL_BYPASS) begin
            bypass_r <= 1'b0; // R18
        end else if (shift_dr && sel == tap_pkg::SEL_BYPASS) begin
            bypass_r <= tdi_s; // R19
        end
    end

    tap_shift_reg #(.W(tap_pkg::ID_W)) u_ident (
        .clock(clock),
        .resetn(resetn),
        .capture(cap_dr && sel == tap_pkg::SEL_IDENT),
        .shift(shift_dr && sel == tap_pkg::SEL_IDENT),
        .cap_value(tap_pkg::ID_VALUE),
        .serial_in(tdi_s),
        .value(id_value)
    ); // R22

    tap_shift_reg #(.W(SCAN_W)) u_scan (
        .clock(clock),
        .resetn(resetn),
        .capture(cap_dr && sel == tap_pkg::SEL_SCAN),
        .shift(shift_dr && sel == tap_pkg::SEL_SCAN),
        .cap_value(scan_pins_in),
        .serial_in(tdi_s),
        .value(scan_value)
    );

    // Preload only reaches the pins under an instruction that drives them, so none does here
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            scan_preload <= '0;
        end else if (upd_dr_fall && sel == tap_pkg::SEL_SCAN) begin
            scan_preload <= scan_value;
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            hiz_r <= 1'b0;
        end else begin
            hiz_r <= (state_r != tap_pkg::ST_RESET) && (ir_r == tap_pkg::OP_HIZ); // R23 R06
        end
    end
    assign outputs_disable = hiz_r;

    // Output changes on the falling test clock edge, as in the standard port
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            tdo <= 1'b0;
            tdo_oe <= 1'b0;
        end else if (fall) begin
            tdo_oe <= state_r == tap_pkg::ST_SHIFT_DR || state_r == tap_pkg::ST_SHIFT_IR; // R20
            if (state_r == tap_pkg::ST_SHIFT_IR) begin
                tdo <= ir_shift_r[0]; // R16
            end else begin
                unique case (sel)
                    tap_pkg::SEL_IDENT: tdo <= id_value[0];
                    tap_pkg::SEL_SCAN: tdo <= scan_value[0];
                    default: tdo <= bypass_r;
                endcase
            end
        end
    end

    // Test logic claims priority over the FIFO only outside test-logic-reset, and in idle only under high impedance
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            test_active <= 1'b0;
            test_reset <= 1'b1;
        end else begin
            test_active <= (state_r != tap_pkg::ST_RESET) && (state_r != tap_pkg::ST_IDLE || hiz_r); // R05 R07
            test_reset <= state_r == tap_pkg::ST_RESET; // R06
        end
    end

    a_five_tms_reset: assert property (@(posedge clock) disable iff (!resetn) // R01
        (tms_high_cnt_r == 3'(tap_pkg::TMS_RESET_CLOCKS)) |-> state_r == tap_pkg::ST_RESET)
        else $error("five mode-select-high clocks did not reach reset");

    a_state_on_rise: assert property (@(posedge clock) disable iff (!resetn || !trstn_s) // R04
        !rise |=> $stable(state_r))
        else $error("state changed without a test clock rise");

    a_sel_dr_branch: assert property (@(posedge clock) disable iff (!resetn || !trstn_s) // R08
        (rise && state_r == tap_pkg::ST_SEL_DR) |=>
        state_r == ($past(tms_s) ? tap_pkg::ST_SEL_IR : tap_pkg::ST_CAP_DR))
        else $error("select data branch wrong");

    a_sel_ir_branch: assert property (@(posedge clock) disable iff (!resetn || !trstn_s) // R09
        (rise && state_r == tap_pkg::ST_SEL_IR) |=>
        state_r == ($past(tms_s) ? tap_pkg::ST_RESET : tap_pkg::ST_CAP_IR))
        else $error("select instruction branch wrong");

    a_ir_capture: assert property (@(posedge clock) disable iff (!resetn) // R10
        (rise && state_r == tap_pkg::ST_CAP_IR) |=> ir_shift_r[1:0] == 2'b01)
        else $error("instruction capture pattern wrong");

    a_ir_pause_hold: assert property (@(posedge clock) disable iff (!resetn) // R12
        (state_r == tap_pkg::ST_PAUSE_IR) |=> $stable(ir_shift_r))
        else $error("instruction stages moved in pause");

    sequence s_upd_fall;
        fall && state_r == tap_pkg::ST_UPD_IR;
    endsequence
    a_ir_update: assert property (@(posedge clock) disable iff (!resetn) // R13
        s_upd_fall |=> ir_r == $past(ir_shift_r))
        else $error("instruction not latched on falling edge");

    a_bypass_clear: assert property (@(posedge clock) disable iff (!resetn) // R18
        (cap_dr && sel == tap_pkg::SEL_BYPASS) |=> !bypass_r)
        else $error("bypass not cleared in capture");

    a_reset_disabled: assert property (@(posedge clock) disable iff (!resetn) // R06
        (state_r == tap_pkg::ST_RESET) |=> ##1 (!outputs_disable && !test_active))
        else $error("test logic active in reset state");

    a_hiz_output: assert property (@(posedge clock) disable iff (!resetn) // R23
        (ir_r == tap_pkg::OP_HIZ && state_r != tap_pkg::ST_RESET) |=> outputs_disable)
        else $error("high-impedance instruction did not disable outputs");

    sequence s_exit1_ir_rise;
        rise && state_r == tap_pkg::ST_EXIT1_IR;
    endsequence
    a_exit1_ir_branch: assert property (@(posedge clock) disable iff (!resetn || !trstn_s) // R12
        s_exit1_ir_rise |=> state_r == ($past(tms_s) ? tap_pkg::ST_UPD_IR : tap_pkg::ST_PAUSE_IR))
        else $error("exit1 instruction branch wrong");

    sequence s_exit1_dr_rise;
        rise && state_r == tap_pkg::ST_EXIT1_DR;
    endsequence
    a_exit1_dr_branch: assert property (@(posedge clock) disable iff (!resetn || !trstn_s) // R15
        s_exit1_dr_rise |=> state_r == ($past(tms_s) ? tap_pkg::ST_UPD_DR : tap_pkg::ST_PAUSE_DR))
        else $error("exit1 data branch wrong");

    sequence s_cap_dr_rise;
        rise && state_r == tap_pkg::ST_CAP_DR;
    endsequence
    a_cap_dr_next: assert property (@(posedge clock) disable iff (!resetn || !trstn_s) // R15
        s_cap_dr_rise |=> state_r == ($past(tms_s) ? tap_pkg::ST_EXIT1_DR : tap_pkg::ST_SHIFT_DR))
        else $error("capture data branch wrong");

    a_ir_shift_step: assert property (@(posedge clock) disable iff (!resetn) // R11
        (rise && state_r == tap_pkg::ST_SHIFT_IR) |=>
        ir_shift_r == {$past(tdi_s), $past(ir_shift_r[tap_pkg::IR_W-1:1])})
        else $error("instruction stages did not shift");

    a_tdo_ir_bit: assert property (@(posedge clock) disable iff (!resetn) // R16
        (fall && state_r == tap_pkg::ST_SHIFT_IR) |=> tdo == $past(ir_shift_r[0]))
        else $error("instruction bit zero not on serial output");

    a_tdo_enable: assert property (@(posedge clock) disable iff (!resetn) // R20
        fall |=>
        tdo_oe == ($past(state_r) == tap_pkg::ST_SHIFT_DR || $past(state_r) == tap_pkg::ST_SHIFT_IR))
        else $error("serial output enable wrong");

    a_bypass_shift: assert property (@(posedge clock) disable iff (!resetn) // R19
        (shift_dr && sel == tap_pkg::SEL_BYPASS) |=> bypass_r == $past(tdi_s))
        else $error("bypass stage did not shift");

    a_ident_capture: assert property (@(posedge clock) disable iff (!resetn) // R14 R22
        (cap_dr && sel == tap_pkg::SEL_IDENT) |=> id_value == tap_pkg::ID_VALUE && id_value[0])
        else $error("identity capture wrong");

    a_decode_ident: assert property (@(posedge clock) disable iff (!resetn) // R21
        (ir_r == tap_pkg::OP_IDENT) |-> sel == tap_pkg::SEL_IDENT)
        else $error("identity code not decoded");

    a_decode_scan: assert property (@(posedge clock) disable iff (!resetn) // R21
        (ir_r == tap_pkg::OP_SCAN) |-> sel == tap_pkg::SEL_SCAN)
        else $error("scan code not decoded");

    a_decode_bypass: assert property (@(posedge clock) disable iff (!resetn) // R25 R24
        (ir_r != tap_pkg::OP_IDENT && ir_r != tap_pkg::OP_SCAN) |-> sel == tap_pkg::SEL_BYPASS)
        else $error("other code did not select bypass");

    a_reset_instr: assert property (@(posedge clock) disable iff (!resetn) // R06
        (state_r == tap_pkg::ST_RESET) |=> ir_r == tap_pkg::IR_RESET)
        else $error("reset state did not restore instruction");

    a_reset_flag: assert property (@(posedge clock) disable iff (!resetn) // R06
        1'b1 |=> test_reset == ($past(state_r) == tap_pkg::ST_RESET))
        else $error("reset flag does not follow state");

    a_pin_reset: assert property (@(posedge clock) disable iff (!resetn) // R20
        !trstn_s |=> state_r == tap_pkg::ST_RESET)
        else $error("reset pin did not force reset state");

    sequence s_dr_paused;
        state_r == tap_pkg::ST_PAUSE_DR;
    endsequence
    a_dr_pause_hold: assert property (@(posedge clock) disable iff (!resetn) // R15
        s_dr_paused |=> $stable(bypass_r) && $stable(id_value) && $stable(scan_value))
        else $error("data register moved in pause");

    a_idle_quiet: assert property (@(posedge clock) disable iff (!resetn) // R07
        (state_r == tap_pkg::ST_IDLE && !hiz_r) |=> !test_active)
        else $error("test logic active in idle");

    a_preload_update: assert property (@(posedge clock) disable iff (!resetn) // R15
        (upd_dr_fall && sel == tap_pkg::SEL_SCAN) |=> scan_preload == $past(scan_value))
        else $error("preload not updated");

    a_shift_active: assert property (@(posedge clock) disable iff (!resetn) // R05
        (state_r == tap_pkg::ST_SHIFT_DR) |=> test_active)
        else $error("test logic lost priority in shift");

    a_hiz_release: assert property (@(posedge clock) disable iff (!resetn) // R23
        (ir_r != tap_pkg::OP_HIZ) |=> !outputs_disable)
        else $error("outputs disabled without high-impedance code");
endmodule
`default_nettype wire

// File: bench/tap_tester.sv
// Tester model that drives the test access port pins
`timescale 1ns/1ps
`default_nettype none
module tap_tester (
    input wire logic clock,
    output logic tck,
    output logic tms,
    output logic tdi,
    output logic trst_n,
    input wire logic tdo
);
    // Test clock rests high between frames
    initial begin
        tck = 1'b1;
        tms = 1'b1;
        tdi = 1'b0;
        trst_n = 1'b1;
    end

    // One 32 ns test clock period: four clocks low, four high; tdo read late in the high phase
    task automatic tick(input logic m, input logic d, input logic use_d, output logic got);
        @(posedge clock);
        tck <= 1'b0;
        tms <= m;
        // Unused serial input keeps toggling so stale data never passes for a shifted bit
        tdi <= use_d ? d : ~tdi;
        repeat (4) @(posedge clock);
        tck <= 1'b1;
        repeat (3) @(posedge clock);
        @(negedge clock);
        got = tdo;
    endtask

    // Controller does not reset itself at power-up
    task automatic pin_reset();
        @(posedge clock);
        trst_n <= 1'b0;
        repeat (8) @(posedge clock);
        trst_n <= 1'b1;
    endtask

    // Scan from idle back to idle; pause_at below zero means no pause
    task automatic scan(input logic is_ir, input int n, input int pause_at, input logic [31:0] din,
                        output logic [31:0] dout);
        logic got;
        dout = '0;
        tick(1'b1, 1'b0, 1'b0, got);
        if (is_ir) begin
            tick(1'b1, 1'b0, 1'b0, got);
        end
        tick(1'b0, 1'b0, 1'b0, got);
        tick(1'b0, 1'b0, 1'b0, got);
        for (int i = 0; i < n; i++) begin
            tick((i == n - 1) || (i == pause_at), din[i], 1'b1, got);
            dout[i] = got;
            if (i == pause_at && i != n - 1) begin
                tick(1'b0, 1'b0, 1'b0, got);
                tick(1'b0, 1'b0, 1'b0, got);
                tick(1'b1, 1'b0, 1'b0, got);
                tick(1'b0, 1'b0, 1'b0, got);
            end
        end
        tick(1'b1, 1'b0, 1'b0, got);
        tick(1'b0, 1'b0, 1'b0, got);
    endtask
endmodule
`default_nettype wire

// File: bench/boundary_scan_tap_controller_tb_top.sv
// Self-checking bench for the boundary-scan test access port
`timescale 1ns/1ps
`default_nettype none
module boundary_scan_tap_controller_tb_top;
    localparam int SCAN_W = 16;
    logic clock, resetn, tck, tms, tdi, trst_n, tdo, tdo_oe, outputs_disable, test_active, test_reset, got;
    logic [SCAN_W-1:0] scan_pins_in, scan_preload;
    logic [31:0] lfsr, din, dout;
    int err_total, cmp_count, cycles;

    tap_ctrl #(.SCAN_W(SCAN_W)) DUT (
        .clock(clock),
        .resetn(resetn),
        .tck(tck),
        .tms(tms),
        .tdi(tdi),
        .trst_n(trst_n),
        .tdo(tdo),
        .tdo_oe(tdo_oe),
        .scan_pins_in(scan_pins_in),
        .scan_preload(scan_preload),
        .outputs_disable(outputs_disable),
        .test_active(test_active),
        .test_reset(test_reset)
    );

    tap_tester tester (
        .clock(clock),
        .tck(tck),
        .tms(tms),
        .tdi(tdi),
        .trst_n(trst_n),
        .tdo(tdo)
    );

    initial begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    function automatic logic [31:0] lfsr_next(input logic [31:0] s);
        return {s[30:0], 1'b0} ^ (s[31] ? 32'h04c1_1db7 : 32'h0000_0000);
    endfunction

    // Thirty-two bits out of the data path under a given code
    function automatic logic [31:0] dr_expect(input logic [3:0] code, input logic [31:0] d,
                                              input logic [SCAN_W-1:0] pins);
        if (code == tap_pkg::OP_IDENT) return tap_pkg::ID_VALUE;
        if (code == tap_pkg::OP_SCAN) return {d[31-SCAN_W:0], pins};
        return {d[30:0], 1'b0};
    endfunction

    task automatic cmp_word(input logic [31:0] g, input logic [31:0] e, input string what);
        cmp_count++;
        if (g !== e) begin
            err_total++;
            $display("wrong value at %0t: %s got %h want %h", $time, what, g, e);
        end
    endtask

    task automatic cmp_flag(input logic g, input logic e, input string what);
        cmp_count++;
        if (g !== e) begin
            err_total++;
            $display("wrong value at %0t: %s got %b want %b", $time, what, g, e);
        end
    endtask

    task automatic final_report();
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Sixteen codes of about fifty test clocks each fit well inside this
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            err_total++;
            $display("wrong value at %0t: run hung", $time);
            final_report();
        end
    end

    initial begin
        resetn = 1'b0;
        scan_pins_in = '0;
        err_total = 0;
        cmp_count = 0;
        lfsr = 32'hbffb_1265;
        repeat (16) @(posedge clock);
        resetn <= 1'b1;
        repeat (4) @(posedge clock);
        tester.pin_reset();
        repeat (8) @(posedge clock);
        cmp_flag(test_reset, 1'b1, "reset flag");
        cmp_flag(test_active, 1'b0, "priority in reset");
        cmp_flag(tdo_oe, 1'b0, "enable in reset");
        tester.tick(1'b0, 1'b0, 1'b0, got);
        tester.scan(1'b0, 32, -1, 32'h0000_0000, dout);
        cmp_word(dout, tap_pkg::ID_VALUE, "ident after reset");
        $display("test reset_and_ident done");

        // Every code, with pauses in one instruction and one data scan
        for (int c = 0; c < 16; c++) begin
            lfsr = lfsr_next(lfsr);
            din = lfsr;
            scan_pins_in <= lfsr[SCAN_W-1:0] ^ lfsr[31:32-SCAN_W];
            tester.scan(1'b1, 4, (c == 5) ? 1 : -1, {28'h000_0000, c[3:0]}, dout);
            cmp_word({28'h000_0000, dout[3:0]}, {28'h000_0000, tap_pkg::IR_CAPTURE}, "ir capture");
            repeat (8) @(posedge clock);
            cmp_flag(outputs_disable, c[3:0] == tap_pkg::OP_HIZ, "outputs disable");
            cmp_flag(test_active, c[3:0] == tap_pkg::OP_HIZ, "idle priority");
            tester.scan(1'b0, 32, (c == 9) ? 13 : -1, din, dout);
            cmp_word(dout, dr_expect(c[3:0], din, scan_pins_in), "data path");
            if (c == 1) begin
                cmp_word({16'h0000, scan_preload}, {16'h0000, din[31:16]}, "preload");
            end
        end
        $display("test code_table done");

        // Five ones from mid-shift under high impedance
        tester.scan(1'b1, 4, -1, {28'h000_0000, tap_pkg::OP_HIZ}, dout);
        tester.tick(1'b1, 1'b0, 1'b0, got);
        tester.tick(1'b0, 1'b0, 1'b0, got);
        tester.tick(1'b0, 1'b0, 1'b0, got);
        tester.tick(1'b0, 1'b0, 1'b0, got);
        repeat (8) @(posedge clock);
        cmp_flag(tdo_oe, 1'b1, "shift enable");
        cmp_flag(test_active, 1'b1, "priority in shift");
        repeat (5) tester.tick(1'b1, 1'b0, 1'b0, got);
        repeat (8) @(posedge clock);
        cmp_flag(test_reset, 1'b1, "five ones reach reset");
        cmp_flag(outputs_disable, 1'b0, "outputs freed in reset");
        tester.tick(1'b0, 1'b0, 1'b0, got);
        tester.scan(1'b0, 32, -1, 32'h0000_0000, dout);
        cmp_word(dout, tap_pkg::ID_VALUE, "ident after five ones");
        $display("test tms_reset done");
        final_report();
    end
endmodule
`default_nettype wire
